// ---- hdl/trc_capture.sv ----
`timescale 1ns/1ps
`default_nettype none
// Receive clocks are sampled by mclk; edges are found after two-flop sync.
module trc_capture (
    input  wire logic            mclk,
    input  wire logic            rst_b,
    input  wire logic            single_clock_mode,
    input  wire logic            recv_clock_even,
    input  wire logic            recv_clock_odd,
    input  wire logic [9:0]      code_group_even_pad,
    input  wire logic [9:0]      code_group_odd_pad,
    output logic                 pair_valid,
    output trc_pkg::trc_pair_s   pair_data
);
    // Sync stages: clocks and data pads alike
    logic [1:0]  ev_s_q;
    logic [1:0]  od_s_q;
    logic        ev_prev_q;
    logic        od_prev_q;
    trc_pkg::trc_cg_t de_s1_q;
    trc_pkg::trc_cg_t de_s2_q;
    trc_pkg::trc_cg_t dd_s1_q;
    trc_pkg::trc_cg_t dd_s2_q;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ev_s_q  <= 2'h0;
            od_s_q  <= 2'h0;
            de_s1_q <= trc_pkg::CG_RST;
            de_s2_q <= trc_pkg::CG_RST;
            dd_s1_q <= trc_pkg::CG_RST;
            dd_s2_q <= trc_pkg::CG_RST;
        end else begin
            ev_s_q  <= {ev_s_q[0], recv_clock_even};
            od_s_q  <= {od_s_q[0], recv_clock_odd};
            de_s1_q <= code_group_even_pad;
            de_s2_q <= de_s1_q;
            dd_s1_q <= code_group_odd_pad;
            dd_s2_q <= dd_s1_q;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ev_prev_q <= 1'b0;
            od_prev_q <= 1'b0;
        end else begin
            ev_prev_q <= ev_s_q[1];
            od_prev_q <= od_s_q[1];
        end
    end

    // Rising-edge test shared by both synchronised receive clocks
    function automatic logic edge_rise(input logic cur, input logic prev);
        edge_rise = cur & ~prev;
    endfunction

    logic ev_rise;
    logic ev_fall;
    logic od_rise;
    logic alt_rise;
    trc_pkg::trc_cg_t alt_data;
    assign ev_rise = edge_rise(ev_s_q[1], ev_prev_q);
    assign ev_fall = ~ev_s_q[1] & ev_prev_q;
    assign od_rise = edge_rise(od_s_q[1], od_prev_q);
    // Odd clock ignored in single mode; even falling edge replaces it
    assign alt_rise = single_clock_mode ? ev_fall : od_rise;
    assign alt_data = single_clock_mode ? de_s2_q : dd_s2_q;

    // Capture registers, one per edge; each bit has its own pad per clock
    trc_pkg::trc_cg_t cap_ev_q;
    trc_pkg::trc_cg_t cap_alt_q;
    logic             have_ev_q;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cap_ev_q  <= trc_pkg::CG_RST;
            have_ev_q <= 1'b0;
        end else if (ev_rise) begin
            cap_ev_q  <= de_s2_q;
            have_ev_q <= 1'b1;
        end else if (alt_rise) begin
            have_ev_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cap_alt_q <= trc_pkg::CG_RST;
        end else if (alt_rise && have_ev_q) begin
            cap_alt_q <= alt_data;
        end
    end

    // Pair is complete once the alternate word follows an even word
    logic pair_done_q;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pair_done_q <= 1'b0;
        end else begin
            pair_done_q <= alt_rise & have_ev_q;
        end
    end

    // Second stage; single mode presents both words on the next even rise
    logic pend_q;
    logic launch;
    assign launch = single_clock_mode ? (ev_rise & pend_q) : pair_done_q;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pend_q <= 1'b0;
        end else if (pair_done_q) begin
            pend_q <= 1'b1;
        end else if (launch) begin
            pend_q <= 1'b0;
        end
    end

    // Single mode: the next even rise reloads cap_ev_q, so keep a copy
    // of the finished pair until it is launched.
    trc_pkg::trc_pair_s held_q;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            held_q <= '0;
        end else if (pair_done_q) begin
            held_q.first  <= cap_ev_q;
            held_q.second <= cap_alt_q;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pair_data  <= '0;
            pair_valid <= 1'b0;
        end else begin
            pair_valid <= launch;
            if (launch) begin
                pair_data <= single_clock_mode ? held_q
                    : trc_pkg::trc_pair_s'{first: cap_ev_q, second: cap_alt_q};
            end
        end
    end
    // No shared state: every instance owns its sync and capture flops.

    // Two-clock hand-over: odd edge completes the pair, mode holds a cycle
    sequence seq_two_pair_done;
        (!single_clock_mode && od_rise && have_ev_q) ##1 !single_clock_mode;
    endsequence

    // Single-clock hand-over waits for the even rise after the pair
    sequence seq_single_launch;
        single_clock_mode && pend_q && ev_rise;
    endsequence

    AST_VALID_PULSE: assert property (@(posedge mclk) disable iff (!rst_b)
        pair_valid |=> !pair_valid)
        else $error("pair_valid longer than one cycle");

    AST_TWO_LATENCY: assert property (@(posedge mclk) disable iff (!rst_b)
        seq_two_pair_done |=> pair_valid)
        else $error("pair not handed over after odd edge");

    AST_ONE_LATENCY: assert property (@(posedge mclk) disable iff (!rst_b)
        seq_single_launch |=> pair_valid && (pair_data == $past(held_q)))
        else $error("single mode pair not handed over on even rise");

    // An alternate edge with no even word before it must be dropped
    AST_NO_ORPHAN: assert property (@(posedge mclk) disable iff (!rst_b)
        (alt_rise && !have_ev_q) |=> !pair_done_q)
        else $error("pair completed from orphan alternate edge");

    AST_SINGLE_ALT: assert property (@(posedge mclk) disable iff (!rst_b)
        (single_clock_mode && ev_fall && have_ev_q) |=> cap_alt_q == $past(de_s2_q))
        else $error("falling edge word not captured");

    // Output word only moves together with its strobe
    AST_DATA_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
        !pair_valid |-> $stable(pair_data))
        else $error("pair_data changed without pair_valid");

    AST_HELD_ORDER: assert property (@(posedge mclk) disable iff (!rst_b)
        pair_done_q |=> held_q.first == $past(cap_ev_q))
        else $error("held pair order wrong");

    AST_TWO_ODD_EDGE: assert property (@(posedge mclk) disable iff (!rst_b)
        (!single_clock_mode && pair_done_q) |-> $past(od_rise))
        else $error("two-clock pair not closed by odd edge");

    AST_SINGLE_FALL: assert property (@(posedge mclk) disable iff (!rst_b)
        (single_clock_mode && pair_done_q) |-> $past(ev_fall))
        else $error("single mode pair not closed by even fall");

    AST_TWO_SECOND: assert property (@(posedge mclk) disable iff (!rst_b)
        (!single_clock_mode && launch) |=> pair_data.second == $past(cap_alt_q))
        else $error("second word of pair wrong");

    AST_ALT_AFTER_EV: assert property (@(posedge mclk) disable iff (!rst_b)
        pair_done_q |-> $past(have_ev_q))
        else $error("pair completed without even word");

    AST_ONE_ON_RISE: assert property (@(posedge mclk) disable iff (!rst_b)
        (single_clock_mode && pair_valid) |-> $past(ev_rise))
        else $error("single mode word not on even rise");

    AST_ODD_IGNORED: assert property (@(posedge mclk) disable iff (!rst_b)
        (single_clock_mode && od_rise && !ev_fall && have_ev_q) |=> have_ev_q)
        else $error("odd clock used in single mode");

    AST_EV_CAPTURE: assert property (@(posedge mclk) disable iff (!rst_b)
        ev_rise |=> (cap_ev_q == $past(de_s2_q)) && have_ev_q)
        else $error("even word not captured");

    AST_TWO_DATA: assert property (@(posedge mclk) disable iff (!rst_b)
        (!single_clock_mode && od_rise && have_ev_q) |=> cap_alt_q == $past(dd_s2_q))
        else $error("odd pad word not captured");

    AST_ORDER: assert property (@(posedge mclk) disable iff (!rst_b)
        (!single_clock_mode && launch) |=> pair_data.first == $past(cap_ev_q))
        else $error("pair order wrong");
endmodule
`default_nettype wire

// ---- hdl/trc_pkg.sv ----
`default_nettype none
package trc_pkg;
    localparam int CG_W = 10;
    localparam logic [9:0] CG_RST = 10'h000;

    typedef logic [CG_W-1:0] trc_cg_t;

    // Pair of code-groups, even-edge word first in time
    typedef struct packed {
        trc_cg_t first;
        trc_cg_t second;
    } trc_pair_s;

    typedef enum logic {
        TRC_MODE_TWO_CLOCK,
        TRC_MODE_ONE_CLOCK
    } trc_mode_e;
endpackage
`default_nettype wire

// ---- testbench/trc_serdes_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module trc_serdes_model (
    output logic       recv_clock_even,
    output logic       recv_clock_odd,
    output logic [9:0] code_group
);
    initial begin
        recv_clock_even = 1'b0;
        recv_clock_odd  = 1'b0;
        code_group      = 10'h000;
    end
    // Back-to-back pairs keep a 125 ns period; odd drops at the next even rise
    task automatic send_pair(input logic [9:0] a, input logic [9:0] b);
        code_group = a;
        #31 recv_clock_even = 1'b1;
        recv_clock_odd = 1'b0;
        #31 code_group = b;
        #31.5 recv_clock_even = 1'b0;
        recv_clock_odd = 1'b1;
        #31.5;
    endtask
    // Clocks stand still after a burst; released bus shows inverted data
    task automatic end_burst(input logic [9:0] b);
        code_group = ~b;
        #31 recv_clock_odd = 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- testbench/tbi_receive_capture_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tbi_receive_capture_tb_top;
    logic               mclk = 1'b0;
    logic               rst_b = 1'b0;
    logic               single_clock_mode = 1'b0;
    logic               even_clk;
    logic               odd_clk;
    logic [9:0]         cg;
    logic               pair_valid;
    trc_pkg::trc_pair_s pair_data;
    trc_pkg::trc_pair_s seen[$];
    logic [9:0]         words[6] = '{10'h3ff, 10'h000, 10'h155, 10'h2aa, 10'h0f0, 10'h30f};
    int                 num_errors = 0;
    int                 check_count = 0;
    always #5 mclk = ~mclk;
    trc_serdes_model partner (.recv_clock_even(even_clk), .recv_clock_odd(odd_clk),
        .code_group(cg));
    trc_capture dut (.mclk(mclk), .rst_b(rst_b), .single_clock_mode(single_clock_mode),
        .recv_clock_even(even_clk), .recv_clock_odd(odd_clk), .code_group_even_pad(cg),
        .code_group_odd_pad(cg), .pair_valid(pair_valid), .pair_data(pair_data));
    always @(posedge mclk) if (pair_valid === 1'b1) seen.push_back(pair_data);
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic compare_count(input int exp, input int got);
        check_count++;
        if (got != exp) begin
            $display("unexpected pair count expected %0d seen %0d", exp, got);
            num_errors++;
        end
    endtask
    task automatic compare_pair(input int i);
        trc_pkg::trc_pair_s exp;
        exp = '{first: words[2*i], second: words[2*i+1]};
        check_count++;
        if (seen[i] !== exp) begin
            $display("unexpected pair_data expected %h seen %h", exp, seen[i]);
            num_errors++;
        end
    endtask
    // Mid-run reset also flushes any half-built pair
    task automatic do_reset(input logic mode);
        rst_b <= 1'b0;
        single_clock_mode <= mode;
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (2) @(posedge mclk);
        seen.delete();
    endtask
    task automatic send_and_wait(input int n);
        for (int i = 0; i < 3; i++) partner.send_pair(words[2*i], words[2*i+1]);
        partner.end_burst(words[5]);
        for (int k = 0; k < 300 && seen.size() < n; k++) @(posedge mclk);
        if (seen.size() < n) begin
            num_errors++;
            end_of_test();
        end
        repeat (60) @(posedge mclk);
    endtask
    task automatic test_two_clock;
        do_reset(1'b0);
        send_and_wait(3);
        compare_count(3, seen.size());
        for (int i = 0; i < 3; i++) compare_pair(i);
        $display("test_two_clock done");
    endtask
    // Last pair waits for a following even rise, so only two appear
    task automatic test_single_clock;
        do_reset(1'b1);
        send_and_wait(2);
        compare_count(2, seen.size());
        for (int i = 0; i < 2; i++) compare_pair(i);
        $display("test_single_clock done");
    endtask
    initial begin
        test_two_clock();
        test_single_clock();
        end_of_test();
    end
endmodule
`default_nettype wire
